// ---- hdl/flash_regs.svh ----
// Opcodes, status bit positions, array geometry and timing defaults.
// Included by the package, the sequencer and the bench; definitions only.
`ifndef FLASH_REGS_SVH
`define FLASH_REGS_SVH

// Opcodes; bit 3 is don't-care
`define OPC_CARE_MASK       8'hF7
`define OPC_WRITE_ENABLE    8'h06
`define OPC_WRITE_DISABLE   8'h04
`define OPC_STATUS_READ     8'h05
`define OPC_STATUS_WRITE    8'h01
`define OPC_READ            8'h03
`define OPC_PROGRAM         8'h02
`define OPC_SECTOR_ERASE    8'h52
`define OPC_CHIP_ERASE      8'h62

// Status byte layout
`define ST_BUSY_BIT         0
`define ST_WEL_BIT          1
`define ST_BP_BIT           2
`define ST_HWPE_BIT         7
`define ST_BUSY_BYTE        8'hFF
`define ST_WEL_RST          1'b0
`define ST_BP_RST           1'b0
`define ST_HWPE_RST         1'b0

// Array geometry
`define ADDR_W              16
`define PAGE_W              7
`define PAGE_BYTES          128
`define SECTOR_BIT          15
`define ERASED_BYTE         8'hFF
`define LAST_ADDR_BYTE      2'h2

// Timing
`define CLK_MHZ             10
`define PROG_TIME_US        100
`define STATUS_WRITE_US     100
`define SECTOR_ERASE_MS     500
`define CHIP_ERASE_MS       2000

`endif

// ---- hdl/flash_pkg.sv ----
// Types shared by the flash sequencer.
// Assumes flash_regs.svh is on the include path.
package flash_pkg;
`include "flash_regs.svh"

    typedef enum logic [2:0] {
        PH_CMD    = 3'h0,
        PH_ADDR   = 3'h1,
        PH_RDATA  = 3'h2,
        PH_SDATA  = 3'h3,
        PH_PDATA  = 3'h4,
        PH_WSDATA = 3'h5,
        PH_IGNORE = 3'h6
    } phase_t;

    typedef enum logic [1:0] {
        EN_IDLE  = 2'h0,
        EN_DRAIN = 2'h1,
        EN_WALK  = 2'h2,
        EN_WAIT  = 2'h3
    } engine_t;

    typedef enum logic [1:0] {
        OP_PROG   = 2'h0,
        OP_SERASE = 2'h1,
        OP_CERASE = 2'h2,
        OP_WSR    = 2'h3
    } wop_t;

    typedef struct packed {
        logic [1:0]             cs_s;
        logic [1:0]             sck_s;
        logic [1:0]             si_s;
        logic [1:0]             wp_s;
        logic                   cs_prev;
        logic                   sck_prev;
        phase_t                 phase;
        logic [2:0]             bitcnt;
        logic [7:0]             sh;
        logic [7:0]             opc;
        logic [1:0]             abytes;
        logic [`ADDR_W-1:0]     addr;
        logic [`PAGE_W-1:0]     poff;
        logic [`PAGE_BYTES-1:0] mask;
        logic                   armed;
        wop_t                   aop;
        logic [1:0]             new_bits;
        engine_t                eng;
        wop_t                   op;
        logic [`ADDR_W-1:0]     wcnt;
        logic [`ADDR_W-1:0]     wend;
        logic [31:0]            timer;
        logic                   so;
        logic                   so_oe_n;
        logic                   wel;
        logic                   hwpe;
        logic                   bp;
        logic                   busy;
    } seq_state_t;

endpackage : flash_pkg

// ---- hdl/sync_fifo.sv ----
// Single-clock FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two.
`timescale 1ns/100ps
`default_nettype none
module sync_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic             in_valid,
    output var  logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output var  logic             out_valid,
    input  wire logic             out_ready,
    output var  logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   cnt;
    } fifo_state_t;

    fifo_state_t q;
    fifo_state_t d;
    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic push;
    logic pop;

    assign in_ready  = (q.cnt != (AW+1)'(DEPTH));
    assign out_valid = (q.cnt != '0);
    assign out_data  = store[q.rd];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        d = q;
        if (push) begin
            d.wr = q.wr + 1'b1;
        end
        if (pop) begin
            d.rd = q.rd + 1'b1;
        end
        if (push && !pop) begin
            d.cnt = q.cnt + 1'b1;
        end else if (pop && !push) begin
            d.cnt = q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            store[q.wr] <= in_data;
        end
    end
endmodule : sync_fifo
`default_nettype wire

// ---- hdl/serial_flash_array_ops.sv ----
// Serial flash command sequencer: SPI mode 0 slave, array, protection, self-timed cycles.
// Assumes SCK, CS_N, SI and WP_N are asynchronous pins, SCK well below REF_CLK/4.
`timescale 1ns/100ps
`default_nettype none
`include "flash_regs.svh"
module serial_flash_array_ops #(
    parameter int PROG_TIME_US    = `PROG_TIME_US,
    parameter int STATUS_WRITE_US = `STATUS_WRITE_US,
    parameter int SECTOR_ERASE_MS = `SECTOR_ERASE_MS,
    parameter int CHIP_ERASE_MS   = `CHIP_ERASE_MS,
    parameter int FIFO_DEPTH      = 16
) (
    // Clock and reset
    input  wire logic REF_CLK,
    input  wire logic NRST,
    // SPI link
    input  wire logic CS_N,
    input  wire logic SCK,
    input  wire logic SI,
    output var  logic SO,
    output var  logic SO_OE_N,
    // Protect pin
    input  wire logic WP_N,
    // Status view
    output var  logic BUSY,
    output var  logic WEL,
    output var  logic HW_PROTECT_ENABLE_BIT,
    output var  logic BLOCK_PROTECT_BIT
);
    import flash_pkg::*;

    localparam int PROG_CYC   = PROG_TIME_US * `CLK_MHZ;
    localparam int WSR_CYC    = STATUS_WRITE_US * `CLK_MHZ;
    localparam int SERASE_CYC = SECTOR_ERASE_MS * 1000 * `CLK_MHZ;
    localparam int CERASE_CYC = CHIP_ERASE_MS * 1000 * `CLK_MHZ;
    localparam int FW         = `PAGE_W + 8;

    seq_state_t q;
    seq_state_t d;

    // Array is kept without reset; it models non-volatile contents
    logic [7:0] mem  [0:(1 << `ADDR_W)-1];
    logic [7:0] pbuf [0:`PAGE_BYTES-1];

    logic               mem_we;
    logic [`ADDR_W-1:0] mem_wa;
    logic [7:0]         mem_wd;
    logic               f_in_valid;
    logic               f_in_ready;
    logic [FW-1:0]      f_in_data;
    logic               f_out_valid;
    logic               f_out_ready;
    logic [FW-1:0]      f_out_data;
    logic               sck_rise;
    logic               sck_fall;
    logic               cs_rise;
    logic               cs_fall;
    logic               cs_low;
    logic               byte_done;
    logic               hw_prot;
    logic               arr_ok;
    logic               sr_ok;
    logic [7:0]         rx;
    logic [7:0]         tx;

    function automatic logic op_is(input logic [7:0] opc, input logic [7:0] code);
        return (opc & `OPC_CARE_MASK) == (code & `OPC_CARE_MASK);
    endfunction : op_is

    function automatic logic [7:0] status_byte(input seq_state_t s);
        logic [7:0] b;
        b = 8'h00;
        if (s.busy) begin
            b = `ST_BUSY_BYTE;
        end else begin
            b[`ST_HWPE_BIT] = s.hwpe;
            b[`ST_BP_BIT]   = s.bp;
            b[`ST_WEL_BIT]  = s.wel;
        end
        return b;
    endfunction : status_byte

    function automatic logic [31:0] wait_cycles(input wop_t op);
        logic [31:0] c;
        c = 32'h0000_0001;
        unique case (op)
            OP_PROG:   c = 32'(PROG_CYC);
            OP_WSR:    c = 32'(WSR_CYC);
            OP_SERASE: c = 32'(SERASE_CYC);
            OP_CERASE: c = 32'(CERASE_CYC);
        endcase
        return c;
    endfunction : wait_cycles

    // Bytes are queued as {page offset, data} so wrap order survives the queue
    sync_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_load_fifo (
        .clk       (REF_CLK),
        .rst_n     (NRST),
        .in_valid  (f_in_valid),
        .in_ready  (f_in_ready),
        .in_data   (f_in_data),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data)
    );

    always_comb begin
        d = q;
        d.cs_s  = {q.cs_s[0], CS_N};
        d.sck_s = {q.sck_s[0], SCK};
        d.si_s  = {q.si_s[0], SI};
        d.wp_s  = {q.wp_s[0], WP_N};
        d.cs_prev  = q.cs_s[1];
        d.sck_prev = q.sck_s[1];

        cs_low    = ~q.cs_s[1];
        cs_fall   = ~q.cs_s[1] & q.cs_prev;
        cs_rise   = q.cs_s[1] & ~q.cs_prev;
        sck_rise  = cs_low & q.sck_s[1] & ~q.sck_prev;
        sck_fall  = cs_low & ~q.sck_s[1] & q.sck_prev;
        byte_done = sck_rise & (q.bitcnt == 3'h7);
        rx        = {q.sh[6:0], q.si_s[1]};
        hw_prot   = q.hwpe & ~q.wp_s[1];
        arr_ok    = q.wel & ~q.bp;
        sr_ok     = q.wel & ~hw_prot;
        tx        = (q.phase == PH_SDATA) ? status_byte(q) : mem[q.addr];

        mem_we      = 1'b0;
        mem_wa      = '0;
        mem_wd      = 8'h00;
        f_in_valid  = 1'b0;
        f_in_data   = '0;
        // Page buffer is frozen while it is being committed
        f_out_ready = (q.eng != EN_WALK);

        if (cs_fall) begin
            d.phase  = PH_CMD;
            d.bitcnt = 3'h0;
            d.abytes = 2'h0;
            d.armed  = 1'b0;
        end

        if (sck_rise) begin
            d.bitcnt = q.bitcnt + 3'h1;
            d.sh     = rx;
        end

        if (byte_done) begin
            unique case (q.phase)
                PH_CMD: begin
                    d.opc   = rx;
                    d.phase = PH_IGNORE;
                    if (q.busy) begin
                        if (op_is(rx, `OPC_STATUS_READ)) begin
                            d.phase = PH_SDATA;
                        end
                    end else if (op_is(rx, `OPC_WRITE_ENABLE)) begin
                        d.wel = 1'b1;
                    end else if (op_is(rx, `OPC_WRITE_DISABLE)) begin
                        d.wel = 1'b0;
                    end else if (op_is(rx, `OPC_STATUS_READ)) begin
                        d.phase = PH_SDATA;
                    end else if (op_is(rx, `OPC_READ)) begin
                        d.phase = PH_ADDR;
                    end else if (op_is(rx, `OPC_PROGRAM) || op_is(rx, `OPC_SECTOR_ERASE)) begin
                        if (arr_ok) begin
                            d.phase = PH_ADDR;
                            d.mask  = '0;
                        end
                    end else if (op_is(rx, `OPC_CHIP_ERASE)) begin
                        if (arr_ok) begin
                            d.armed = 1'b1;
                            d.aop   = OP_CERASE;
                        end
                    end else if (op_is(rx, `OPC_STATUS_WRITE)) begin
                        if (sr_ok) begin
                            d.phase = PH_WSDATA;
                        end
                    end
                end
                PH_ADDR: begin
                    d.addr   = {q.addr[7:0], rx};
                    d.abytes = q.abytes + 2'h1;
                    if (q.abytes == `LAST_ADDR_BYTE) begin
                        if (op_is(q.opc, `OPC_READ)) begin
                            d.phase = PH_RDATA;
                        end else if (op_is(q.opc, `OPC_PROGRAM)) begin
                            d.phase = PH_PDATA;
                            d.poff  = rx[`PAGE_W-1:0];
                        end else begin
                            d.phase = PH_IGNORE;
                            d.armed = 1'b1;
                            d.aop   = OP_SERASE;
                        end
                    end
                end
                PH_RDATA: begin
                    d.addr = q.addr + 1'b1;
                end
                PH_PDATA: begin
                    f_in_valid = 1'b1;
                    f_in_data  = {q.poff, rx};
                    // A full queue drops the byte rather than stalling the link
                    if (f_in_ready) begin
                        d.poff  = q.poff + 1'b1;
                        d.armed = 1'b1;
                        d.aop   = OP_PROG;
                    end
                end
                PH_WSDATA: begin
                    d.new_bits = {rx[`ST_HWPE_BIT], rx[`ST_BP_BIT]};
                    d.armed    = 1'b1;
                    d.aop      = OP_WSR;
                    d.phase    = PH_IGNORE;
                end
                default: begin
                end
            endcase
        end

        if (sck_fall && (q.phase == PH_RDATA || q.phase == PH_SDATA)) begin
            d.so      = tx[~q.bitcnt];
            d.so_oe_n = 1'b0;
        end

        if (cs_rise) begin
            d.so_oe_n = 1'b1;
            d.phase   = PH_IGNORE;
            d.armed   = 1'b0;
            // Protect pin falling mid-frame still blocks a pending status write
            if (q.armed && q.bitcnt == 3'h0 && !q.busy &&
                !(q.aop == OP_WSR && hw_prot)) begin
                d.busy = 1'b1;
                d.op   = q.aop;
                d.eng  = EN_DRAIN;
                unique case (q.aop)
                    OP_PROG: begin
                        d.wcnt = {q.addr[`ADDR_W-1:`PAGE_W], `PAGE_W'(0)};
                        d.wend = {q.addr[`ADDR_W-1:`PAGE_W], {`PAGE_W{1'b1}}};
                    end
                    OP_SERASE: begin
                        d.wcnt = {q.addr[`SECTOR_BIT], 15'h0000};
                        d.wend = {q.addr[`SECTOR_BIT], 15'h7FFF};
                    end
                    OP_CERASE: begin
                        d.wcnt = '0;
                        d.wend = '1;
                    end
                    OP_WSR: begin
                        d.eng   = EN_WAIT;
                        d.timer = wait_cycles(OP_WSR) - 32'h1;
                    end
                endcase
            end
        end

        if (f_out_valid && f_out_ready) begin
            d.mask[f_out_data[FW-1:8]] = 1'b1;
        end

        unique case (q.eng)
            EN_IDLE: begin
            end
            EN_DRAIN: begin
                if (!f_out_valid) begin
                    d.eng = EN_WALK;
                end
            end
            EN_WALK: begin
                mem_wa = q.wcnt;
                if (q.op == OP_PROG) begin
                    mem_we = q.mask[q.wcnt[`PAGE_W-1:0]];
                    mem_wd = pbuf[q.wcnt[`PAGE_W-1:0]];
                end else begin
                    mem_we = 1'b1;
                    mem_wd = `ERASED_BYTE;
                end
                d.wcnt = q.wcnt + 1'b1;
                if (q.wcnt == q.wend) begin
                    d.eng   = EN_WAIT;
                    d.timer = wait_cycles(q.op) - 32'h1;
                end
            end
            EN_WAIT: begin
                if (q.timer == 32'h0) begin
                    d.eng  = EN_IDLE;
                    d.busy = 1'b0;
                    d.wel  = 1'b0;
                    if (q.op == OP_WSR) begin
                        d.hwpe = q.new_bits[1];
                        d.bp   = q.new_bits[0];
                    end
                end else begin
                    d.timer = q.timer - 32'h1;
                end
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            q         <= '0;
            q.cs_s    <= 2'h3;
            q.sck_s   <= 2'h0;
            q.wp_s    <= 2'h3;
            q.cs_prev <= 1'b1;
            q.phase   <= PH_IGNORE;
            q.so_oe_n <= 1'b1;
            q.wel     <= `ST_WEL_RST;
            q.hwpe    <= `ST_HWPE_RST;
            q.bp      <= `ST_BP_RST;
        end else begin
            q <= d;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
        if (f_out_valid && f_out_ready) begin
            pbuf[f_out_data[FW-1:8]] <= f_out_data[7:0];
        end
    end

    assign SO                    = q.so;
    assign SO_OE_N               = q.so_oe_n;
    assign BUSY                  = q.busy;
    assign WEL                   = q.wel;
    assign HW_PROTECT_ENABLE_BIT = q.hwpe;
    assign BLOCK_PROTECT_BIT     = q.bp;
endmodule : serial_flash_array_ops
`default_nettype wire

// ---- tb/serial_flash_array_ops_asserts.sv ----
// Concurrent checks on the flash sequencer's top-level pins.
// Sees only the top ports; attached by the bind after the module.
`timescale 1ns/100ps
`default_nettype none
module flash_seq_chk (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic NRST,
    // Link
    input wire logic CS_N,
    input wire logic SCK,
    input wire logic SO,
    input wire logic SO_OE_N,
    input wire logic WP_N,
    // Status view
    input wire logic BUSY,
    input wire logic WEL,
    input wire logic HW_PROTECT_ENABLE_BIT
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    // Five samples high covers the select synchroniser
    sequence s_deselected; CS_N [*5]; endsequence
    sequence s_locked; (!WP_N && HW_PROTECT_ENABLE_BIT) [*4]; endsequence
    sequence s_cycle_start; $rose(BUSY); endsequence
    property p_oe_off; s_deselected |-> SO_OE_N; endproperty
    property p_hw_hold; s_locked |=> HW_PROTECT_ENABLE_BIT; endproperty
    property p_busy_end; $fell(BUSY) |-> !WEL; endproperty
    property p_busy_cause; s_cycle_start |-> $past(WEL) && CS_N; endproperty
    property p_wel_idle; BUSY |-> WEL; endproperty
    property p_oe_start; $fell(SO_OE_N) |-> !CS_N; endproperty
    property p_so_edge; !SO_OE_N && $changed(SO) |-> !$past(SCK); endproperty
    property p_busy_min; s_cycle_start |-> BUSY [*8]; endproperty
    a_oe_off: assert property (p_oe_off) else $error("SO enabled while deselected");
    a_hw_hold: assert property (p_hw_hold) else $error("protect enable cleared");
    a_busy_end: assert property (p_busy_end) else $error("latch set after cycle");
    a_busy_cause: assert property (p_busy_cause) else $error("cycle without latch");
    a_wel_idle: assert property (p_wel_idle) else $error("latch lost while busy");
    a_oe_start: assert property (p_oe_start) else $error("SO enabled outside frame");
    a_so_edge: assert property (p_so_edge) else $error("SO moved in SCK high");
    a_busy_min: assert property (p_busy_min) else $error("busy too short");
endmodule : flash_seq_chk
bind serial_flash_array_ops flash_seq_chk chk_i (.REF_CLK, .NRST, .CS_N, .SCK, .SO, .SO_OE_N,
    .WP_N, .BUSY, .WEL, .HW_PROTECT_ENABLE_BIT);
`default_nettype wire

// ---- tb/spi_master_model.sv ----
// Behavioural SPI mode 0 master facing the flash sequencer.
// Assumes a free-running reference clock; pins change at its falling edge.
`timescale 1ns/100ps
`default_nettype none
module spi_master_model (
    // Reference clock
    input  wire logic clk,
    // Link
    output var  logic cs_n,
    output var  logic sck,
    output var  logic si,
    input  wire logic so,
    input  wire logic so_oe_n
);
    wire logic so_line;
    assign so_line = so_oe_n ? 1'bz : so;
    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        si   = 1'b0;
    end
    // Each command gets its own select frame
    task automatic sel();
        @(negedge clk);
        cs_n = 1'b0;
    endtask : sel
    // SCK stands still outside frames; 800 ns bit time
    task automatic xb(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) begin
            si = d[i];
            repeat (4) @(negedge clk);
            q[i] = so_line;
            sck = 1'b1;
            repeat (4) @(negedge clk);
            sck = 1'b0;
        end
    endtask : xb
    // Released SI toggles so a stale level is never mistaken for data
    task automatic desel();
        repeat (2) @(negedge clk);
        cs_n = 1'b1;
        si   = ~si;
        repeat (8) @(negedge clk);
    endtask : desel
endmodule : spi_master_model
`default_nettype wire

// ---- tb/serial_flash_array_ops_tb.sv ----
// Self-checking bench for the flash sequencer.
// Assumes the master model and bound checker are compiled with it.
`timescale 1ns/100ps
`default_nettype none
`include "flash_regs.svh"
module serial_flash_array_ops_tb;
    logic       ref_clk;
    logic       nrst;
    logic       wp_n;
    logic       so;
    logic       so_oe_n;
    logic       busy;
    logic       wel;
    logic       hwpe;
    logic       bp;
    wire logic  cs_n;
    wire logic  sck;
    wire logic  si;
    wire logic [7:0] pins;
    logic [7:0] q;
    int         err_total;
    int         num_checks;
    assign pins = {3'h0, so_oe_n, hwpe, bp, wel, busy};
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // Short timings keep each wait under the 50000-cycle budget; the sector erase still takes about 42800 cycles
    serial_flash_array_ops #(.PROG_TIME_US(30), .STATUS_WRITE_US(1), .SECTOR_ERASE_MS(1),
        .CHIP_ERASE_MS(1), .FIFO_DEPTH(16)) dut (
        .REF_CLK(ref_clk), .NRST(nrst), .CS_N(cs_n), .SCK(sck), .SI(si), .SO(so),
        .SO_OE_N(so_oe_n), .WP_N(wp_n), .BUSY(busy), .WEL(wel),
        .HW_PROTECT_ENABLE_BIT(hwpe), .BLOCK_PROTECT_BIT(bp));
    spi_master_model m (.clk(ref_clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so),
        .so_oe_n(so_oe_n));
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic end_sim();
        if (err_total == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    task automatic hdr(input logic [7:0] o, input logic [23:0] a);
        m.sel();
        m.xb(o, q);
        for (int i = 2; i >= 0; i--) m.xb(a[8*i +: 8], q);
    endtask : hdr
    task automatic op1(input logic [7:0] o);
        m.sel();
        m.xb(o, q);
        m.desel();
    endtask : op1
    task automatic wsr(input logic [7:0] d);
        m.sel();
        m.xb(`OPC_STATUS_WRITE, q);
        m.xb(d, q);
        m.desel();
    endtask : wsr
    task automatic rd(input logic [23:0] a);
        hdr(`OPC_READ, a);
        m.xb(8'hFF, q);
        m.desel();
    endtask : rd
    task automatic status_read_cmd(input logic [7:0] e);
        m.sel();
        m.xb(`OPC_STATUS_READ, q);
        m.xb(8'h00, q);
        m.desel();
        chk("status", q, e);
    endtask : status_read_cmd
    // Bounded wait; a stuck cycle counts against the run and ends it
    task automatic wait_idle();
        for (int i = 0; i < 50000 && busy !== 1'b0; i++) @(negedge ref_clk);
        chk("busy", {7'h00, busy}, 8'h00);
        if (busy !== 1'b0) end_sim();
    endtask : wait_idle
    task automatic t_program();
        chk("reset pins", pins, 8'h10);
        hdr(`OPC_PROGRAM, 24'h000010);
        m.xb(8'h55, q);
        m.desel();
        chk("no latch", pins, 8'h10);
        op1(`OPC_WRITE_ENABLE);
        op1(`OPC_WRITE_DISABLE);
        chk("disabled", pins, 8'h10);
        op1(`OPC_WRITE_ENABLE | 8'h08);
        status_read_cmd(8'h02);
        // Two bytes from the page end wrap to the page start; no byte is written twice
        hdr(`OPC_PROGRAM, 24'h00007F);
        m.xb(8'hA5, q);
        m.xb(8'h3C, q);
        m.desel();
        chk("prog busy", pins, 8'h13);
        status_read_cmd(8'hFF);
        wait_idle();
        chk("prog done", pins, 8'h10);
        op1(`OPC_WRITE_ENABLE);
        hdr(`OPC_PROGRAM, 24'h00FFFF);
        m.xb(8'hC3, q);
        m.desel();
        wait_idle();
        hdr(`OPC_READ, 24'h12FFFF);
        m.xb(8'h00, q);
        chk("read top", q, 8'hC3);
        m.xb(8'h00, q);
        chk("read wrap", q, 8'h3C);
        m.desel();
        rd(24'h00007F);
        chk("read page end", q, 8'hA5);
        op1(`OPC_WRITE_ENABLE);
        hdr(`OPC_PROGRAM, 24'h000100);
        for (int i = 0; i <= 128; i++) m.xb(8'(i), q);
        m.desel();
        wait_idle();
        rd(24'h000100);
        chk("overrun", q, 8'h80);
        rd(24'h000101);
        chk("page byte", q, 8'h01);
    endtask : t_program
    task automatic t_protect();
        op1(`OPC_WRITE_ENABLE);
        wsr(8'h80);
        wait_idle();
        chk("hw enable", pins, 8'h18);
        op1(`OPC_WRITE_ENABLE);
        m.sel();
        m.xb(`OPC_STATUS_WRITE, q);
        wp_n = 1'b0;
        m.xb(8'h00, q);
        m.desel();
        chk("mid-frame lock", pins, 8'h1A);
        wp_n = 1'b0;
        op1(`OPC_WRITE_ENABLE);
        wsr(8'h00);
        repeat (20) @(negedge ref_clk);
        chk("hw locked", pins, 8'h1A);
        wp_n = 1'b1;
        wsr(8'h04);
        wait_idle();
        chk("block lock", pins, 8'h14);
        op1(`OPC_WRITE_ENABLE);
        op1(`OPC_CHIP_ERASE);
        chk("locked erase", pins, 8'h16);
        wsr(8'h00);
        wait_idle();
        chk("unlocked", pins, 8'h10);
    endtask : t_protect
    task automatic t_erase();
        op1(`OPC_WRITE_ENABLE);
        hdr(`OPC_SECTOR_ERASE, 24'h00C000);
        m.desel();
        chk("erase busy", pins, 8'h13);
        op1(`OPC_WRITE_DISABLE);
        chk("busy ignores", pins, 8'h13);
        rd(24'h000000);
        chk("read refused", q, 8'hZZ);
        status_read_cmd(8'hFF);
        wait_idle();
        chk("erase done", pins, 8'h10);
        rd(24'h00FFFF);
        chk("erased", q, 8'hFF);
        rd(24'h00007F);
        chk("other sector", q, 8'hA5);
        op1(`OPC_WRITE_ENABLE);
        hdr(`OPC_PROGRAM, 24'h00C001);
        m.xb(8'h5A, q);
        m.desel();
        wait_idle();
        rd(24'h00C000);
        chk("untouched", q, 8'hFF);
        rd(24'h00C001);
        chk("single byte", q, 8'h5A);
    endtask : t_erase
    initial begin
        err_total = 0;
        num_checks = 0;
        nrst = 1'b0;
        wp_n = 1'b1;
        repeat (5) @(negedge ref_clk);
        nrst = 1'b1;
        repeat (5) @(negedge ref_clk);
        t_program();
        t_protect();
        t_erase();
        end_sim();
    end
endmodule : serial_flash_array_ops_tb
`default_nettype wire
